// ### mie_consts.svh
/*
 * offsets, field positions, reset values and fixed figures of the execute block.
 * assumes inclusion by bare name from the execute module.
 */
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

// register byte offsets on the wishbone slave
`define MIE_OFS_COMMAND 12'h000
`define MIE_OFS_STATUS 12'h004
`define MIE_OFS_WORKING 12'h008
`define MIE_OFS_FLAGS 12'h00C
`define MIE_OFS_TBL_PTR_LOW 12'h010
`define MIE_OFS_TBL_PTR_HIGH 12'h014
`define MIE_OFS_TBL_HIGH_LATCH 12'h018
`define MIE_OFS_SECTION 12'h01C
`define MIE_OFS_SKIP_COUNT 12'h020
// data memory window: byte address = base + 4 * data address
`define MIE_DMEM_BASE_BIT 11

// command word fields
`define MIE_CMD_ADDR_LSB 0
`define MIE_CMD_BIT_LSB 9
`define MIE_CMD_OP_LSB 12
`define MIE_CMD_IMM_LSB 24

// flag register bit positions
`define MIE_FLAG_CARRY 0
`define MIE_FLAG_HALF 1
`define MIE_FLAG_ZERO 2
`define MIE_FLAG_RANGE 3
`define MIE_FLAG_SIGN 4

// status register bit positions
`define MIE_STAT_BUSY 0
`define MIE_STAT_SKIP 1

// reset values
`define MIE_RST_BYTE 8'h00
`define MIE_RST_FLAGS 5'h00

// decimal adjust figures
`define MIE_BCD_MAX_DIGIT 4'h9
`define MIE_BCD_ADJUST 4'h6

`endif

// ### mie_pkg.sv
/*
 * types shared by the execute block: operation codes and sequencer states.
 * assumes nothing beyond a systemverilog compiler.
 */
package mie_pkg;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_NIBBLE_SWAP_TO_W,
        OP_SKIP_IF_ZERO,
        OP_SKIP_ZERO_LOAD_W,
        OP_SKIP_IF_BIT_ZERO,
        OP_TABLE_READ_PAGE,
        OP_TABLE_READ_FINAL_PAGE,
        OP_TABLE_READ_PREINC,
        OP_TABLE_READ_FINAL_PREINC,
        OP_XOR_TO_W,
        OP_XOR_TO_MEMORY,
        OP_XOR_IMMEDIATE,
        OP_EXT_ADD_CARRY,
        OP_EXT_ADD_CARRY_TO_MEM,
        OP_EXT_ADD,
        OP_EXT_ADD_TO_MEM,
        OP_EXT_AND,
        OP_EXT_AND_TO_MEM,
        OP_EXT_CLEAR,
        OP_EXT_CLEAR_BIT,
        OP_EXT_INVERT,
        OP_EXT_INVERT_TO_W,
        OP_EXT_DECIMAL_ADJUST,
        OP_EXT_DECREMENT,
        OP_EXT_DECREMENT_TO_W,
        OP_EXT_INCREMENT,
        OP_EXT_INCREMENT_TO_W,
        OP_EXT_MOVE_TO_W,
        OP_EXT_MOVE_TO_MEM
    } mie_op_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TABLE_WAIT,
        ST_DUMMY
    } mie_state_e;

endpackage : mie_pkg

// ### mie_execute.sv
/*
 * execute datapath for a subset of an 8-bit microcontroller instruction set,
 * with its own data memory, working register, flags and table pointer,
 * reached over a classic wishbone slave.
 * assumes a program memory that answers a read strobe with prog_valid_i
 * and a 16-bit word, all on clk_i.
 */
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mie_consts.svh"

module mie_execute #(
    parameter int DMEM_AW = 9,
    parameter int SECT_AW = 7,
    parameter int PROG_AW = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [PROG_AW-1:0] prog_addr_o,
    output logic prog_rd_o,
    input wire logic prog_valid_i,
    input wire logic [15:0] prog_data_i,
    output logic busy_o,
    output logic skip_o
);

    initial begin
        if (PROG_AW <= 8 || PROG_AW > 16 || SECT_AW >= DMEM_AW || DMEM_AW > 9) begin
            $error("mie_execute: unsupported address widths");
        end
    end

    localparam int DMEM_DEPTH = 1 << DMEM_AW;
    localparam int PAGE_W = PROG_AW - 8;

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] dmem [DMEM_DEPTH];
    logic [7:0] w_r;
    logic [4:0] flags_r;
    logic [7:0] tbl_low_r;
    logic [7:0] tbl_high_r;
    logic [7:0] latch_r;
    logic [DMEM_AW-SECT_AW-1:0] section_r;
    logic [31:0] cmd_r;
    logic [7:0] skip_count_r;
    logic last_skip_r;
    logic [DMEM_AW-1:0] tbl_dest_r;
    mie_pkg::mie_state_e state_r;
    logic [31:0] wb_dat_r;
    logic wb_ack_r;
    logic [PROG_AW-1:0] prog_addr_r;
    logic prog_rd_r;
    logic skip_r;
    logic busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode

    wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
    wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire logic idle = (state_r == mie_pkg::ST_IDLE);
    // writes while an instruction runs are dropped so the datapath never races software
    wire logic wr_ok = bus_wr & idle;
    wire logic is_dmem = wb_adr_i[`MIE_DMEM_BASE_BIT];
    wire logic [DMEM_AW-1:0] bus_dmem_addr = wb_adr_i[DMEM_AW+1:2];
    wire logic hit_cmd = ~is_dmem & (wb_adr_i == `MIE_OFS_COMMAND);
    wire logic hit_stat = ~is_dmem & (wb_adr_i == `MIE_OFS_STATUS);
    wire logic hit_w = ~is_dmem & (wb_adr_i == `MIE_OFS_WORKING);
    wire logic hit_flags = ~is_dmem & (wb_adr_i == `MIE_OFS_FLAGS);
    wire logic hit_tlow = ~is_dmem & (wb_adr_i == `MIE_OFS_TBL_PTR_LOW);
    wire logic hit_thigh = ~is_dmem & (wb_adr_i == `MIE_OFS_TBL_PTR_HIGH);
    wire logic hit_latch = ~is_dmem & (wb_adr_i == `MIE_OFS_TBL_HIGH_LATCH);
    wire logic hit_sect = ~is_dmem & (wb_adr_i == `MIE_OFS_SECTION);
    wire logic hit_skc = ~is_dmem & (wb_adr_i == `MIE_OFS_SKIP_COUNT);
    wire logic start = wr_ok & hit_cmd & (wb_sel_i == 4'hF);

    // unmapped addresses read as zero and still acknowledge
    wire logic [31:0] rd_mux =
        is_dmem ? {24'h00_0000, dmem[bus_dmem_addr]} :
        hit_cmd ? cmd_r :
        hit_stat ? {30'h0000_0000, last_skip_r, ~idle} :
        hit_w ? {24'h00_0000, w_r} :
        hit_flags ? {27'h000_0000, flags_r} :
        hit_tlow ? {24'h00_0000, tbl_low_r} :
        hit_thigh ? {24'h00_0000, tbl_high_r} :
        hit_latch ? {24'h00_0000, latch_r} :
        hit_sect ? {{(32 - DMEM_AW + SECT_AW){1'b0}}, section_r} :
        hit_skc ? {24'h00_0000, skip_count_r} :
        32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // instruction fields

    wire mie_pkg::mie_op_e op = mie_pkg::mie_op_e'(wb_dat_i[`MIE_CMD_OP_LSB +: 5]);
    wire logic [DMEM_AW-1:0] raw_addr = wb_dat_i[`MIE_CMD_ADDR_LSB +: DMEM_AW];
    wire logic [2:0] bit_idx = wb_dat_i[`MIE_CMD_BIT_LSB +: 3];
    wire logic [7:0] imm = wb_dat_i[`MIE_CMD_IMM_LSB +: 8];
    wire logic is_ext = (op >= mie_pkg::OP_EXT_ADD_CARRY);
    // basic forms stay inside the selected section, extended forms take the full address
    wire logic [DMEM_AW-1:0] op_addr =
        is_ext ? raw_addr : {section_r, raw_addr[SECT_AW-1:0]};
    wire logic [7:0] m = dmem[op_addr];
    wire logic c_in = flags_r[`MIE_FLAG_CARRY];
    wire logic with_c = (op == mie_pkg::OP_EXT_ADD_CARRY) | (op == mie_pkg::OP_EXT_ADD_CARRY_TO_MEM);

    // shared adder for both add forms
    wire logic cin_used = with_c & c_in;
    wire logic [4:0] add_lo = {1'b0, w_r[3:0]} + {1'b0, m[3:0]} + {4'h0, cin_used};
    wire logic [8:0] add_sum = {1'b0, w_r} + {1'b0, m} + {8'h00, cin_used};
    wire logic add_ov = (w_r[7] == m[7]) & (add_sum[7] != w_r[7]);

    // decimal adjust of the working register
    wire logic lo_adj = (w_r[3:0] > `MIE_BCD_MAX_DIGIT) | flags_r[`MIE_FLAG_HALF];
    wire logic hi_adj = (w_r[7:4] > `MIE_BCD_MAX_DIGIT) | c_in;
    wire logic [8:0] daa_sum = {1'b0, w_r} +
        {1'b0, (hi_adj ? `MIE_BCD_ADJUST : 4'h0), (lo_adj ? `MIE_BCD_ADJUST : 4'h0)};

    // table address: paged uses both pointer bytes, final page forces the top page
    wire logic pre_inc = (op == mie_pkg::OP_TABLE_READ_PREINC) | (op == mie_pkg::OP_TABLE_READ_FINAL_PREINC);
    wire logic final_pg = (op == mie_pkg::OP_TABLE_READ_FINAL_PAGE) | (op == mie_pkg::OP_TABLE_READ_FINAL_PREINC);
    wire logic [7:0] tbl_low_use = pre_inc ? tbl_low_r + 8'h01 : tbl_low_r;
    wire logic [PROG_AW-1:0] tbl_addr =
        final_pg ? {{PAGE_W{1'b1}}, tbl_low_use} : {tbl_high_r[PAGE_W-1:0], tbl_low_use};

    ////////////////////////////////////////////////////////////////////////////
    // per-instruction outcome

    logic [7:0] res;
    logic wr_w;
    logic wr_m;
    logic upd_z;
    logic upd_arith;
    logic upd_c_only;
    logic skip;
    logic tbl;

    always_comb begin
        res = 8'h00;
        wr_w = 1'b0;
        wr_m = 1'b0;
        upd_z = 1'b0;
        upd_arith = 1'b0;
        upd_c_only = 1'b0;
        skip = 1'b0;
        tbl = 1'b0;
        case (op)
            mie_pkg::OP_NIBBLE_SWAP_TO_W: begin
                res = {m[3:0], m[7:4]};
                wr_w = 1'b1;
            end
            mie_pkg::OP_SKIP_IF_ZERO: begin
                skip = (m == 8'h00);
            end
            mie_pkg::OP_SKIP_ZERO_LOAD_W: begin
                res = m;
                wr_w = 1'b1;
                skip = (m == 8'h00);
            end
            mie_pkg::OP_SKIP_IF_BIT_ZERO: begin
                skip = ~m[bit_idx];
            end
            mie_pkg::OP_TABLE_READ_PAGE, mie_pkg::OP_TABLE_READ_FINAL_PAGE,
            mie_pkg::OP_TABLE_READ_PREINC, mie_pkg::OP_TABLE_READ_FINAL_PREINC: begin
                tbl = 1'b1;
            end
            mie_pkg::OP_XOR_TO_W: begin
                res = w_r ^ m;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_XOR_TO_MEMORY: begin
                res = w_r ^ m;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_XOR_IMMEDIATE: begin
                res = w_r ^ imm;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_ADD_CARRY, mie_pkg::OP_EXT_ADD: begin
                res = add_sum[7:0];
                wr_w = 1'b1;
                upd_arith = 1'b1;
            end
            mie_pkg::OP_EXT_ADD_CARRY_TO_MEM, mie_pkg::OP_EXT_ADD_TO_MEM: begin
                res = add_sum[7:0];
                wr_m = 1'b1;
                upd_arith = 1'b1;
            end
            mie_pkg::OP_EXT_AND: begin
                res = w_r & m;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_AND_TO_MEM: begin
                res = w_r & m;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_CLEAR: begin
                res = 8'h00;
                wr_m = 1'b1;
            end
            mie_pkg::OP_EXT_CLEAR_BIT: begin
                res = m & ~(8'h01 << bit_idx);
                wr_m = 1'b1;
            end
            mie_pkg::OP_EXT_INVERT: begin
                res = ~m;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_INVERT_TO_W: begin
                res = ~m;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_DECIMAL_ADJUST: begin
                res = daa_sum[7:0];
                wr_m = 1'b1;
                upd_c_only = 1'b1;
            end
            mie_pkg::OP_EXT_DECREMENT: begin
                res = m - 8'h01;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_DECREMENT_TO_W: begin
                res = m - 8'h01;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_INCREMENT: begin
                res = m + 8'h01;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_INCREMENT_TO_W: begin
                res = m + 8'h01;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            mie_pkg::OP_EXT_MOVE_TO_W: begin
                res = m;
                wr_w = 1'b1;
            end
            mie_pkg::OP_EXT_MOVE_TO_MEM: begin
                res = w_r;
                wr_m = 1'b1;
            end
            default: begin
                res = 8'h00;
            end
        endcase
    end

    // flag next value; bits not named by the instruction keep their value
    logic [4:0] flags_nxt;
    always_comb begin
        flags_nxt = flags_r;
        if (wb_sel_i[0] & wr_ok & hit_flags) begin
            flags_nxt = wb_dat_i[4:0];
        end else if (start & upd_z) begin
            flags_nxt[`MIE_FLAG_ZERO] = (res == 8'h00);
        end else if (start & upd_arith) begin
            flags_nxt[`MIE_FLAG_CARRY] = add_sum[8];
            flags_nxt[`MIE_FLAG_HALF] = add_lo[4];
            flags_nxt[`MIE_FLAG_ZERO] = (add_sum[7:0] == 8'h00);
            flags_nxt[`MIE_FLAG_RANGE] = add_ov;
            flags_nxt[`MIE_FLAG_SIGN] = add_sum[7] ^ add_ov;
        end else if (start & upd_c_only) begin
            // carry stays set once set and is set when the adjusted byte overflows, so a chain of bytes adds on
            flags_nxt[`MIE_FLAG_CARRY] = c_in | daa_sum[8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: idle -> (table wait) or (dummy) -> idle

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= mie_pkg::ST_IDLE;
            prog_rd_r <= 1'b0;
            prog_addr_r <= '0;
            skip_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            skip_r <= 1'b0;
            case (state_r)
                mie_pkg::ST_IDLE: begin
                    if (start & tbl) begin
                        state_r <= mie_pkg::ST_TABLE_WAIT;
                        prog_addr_r <= tbl_addr;
                        prog_rd_r <= 1'b1;
                        busy_r <= 1'b1;
                    end else if (start & skip) begin
                        state_r <= mie_pkg::ST_DUMMY;
                        skip_r <= 1'b1;
                        busy_r <= 1'b1;
                    end
                end
                mie_pkg::ST_TABLE_WAIT: begin
                    if (prog_valid_i) begin
                        state_r <= mie_pkg::ST_IDLE;
                        prog_rd_r <= 1'b0;
                        busy_r <= 1'b0;
                    end
                end
                mie_pkg::ST_DUMMY: begin
                    // the discarded slot writes nothing anywhere
                    state_r <= mie_pkg::ST_IDLE;
                    busy_r <= 1'b0;
                end
                default: begin
                    state_r <= mie_pkg::ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // architectural registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            w_r <= `MIE_RST_BYTE;
            flags_r <= `MIE_RST_FLAGS;
            tbl_low_r <= `MIE_RST_BYTE;
            tbl_high_r <= `MIE_RST_BYTE;
            latch_r <= `MIE_RST_BYTE;
            section_r <= '0;
            cmd_r <= 32'h0000_0000;
            skip_count_r <= `MIE_RST_BYTE;
            last_skip_r <= 1'b0;
            tbl_dest_r <= '0;
        end else begin
            flags_r <= flags_nxt;
            if (start) begin
                cmd_r <= wb_dat_i;
                last_skip_r <= skip;
            end
            if (start & skip) begin
                skip_count_r <= skip_count_r + 8'h01;
            end
            if (start & wr_w) begin
                w_r <= res;
            end else if (wr_ok & hit_w) begin
                w_r <= wb_dat_i[7:0];
            end
            if (start & tbl) begin
                tbl_low_r <= tbl_low_use;
                tbl_dest_r <= op_addr;
            end else if (wr_ok & hit_tlow) begin
                tbl_low_r <= wb_dat_i[7:0];
            end
            if (wr_ok & hit_thigh) begin
                tbl_high_r <= wb_dat_i[7:0];
            end
            if (state_r == mie_pkg::ST_TABLE_WAIT && prog_valid_i) begin
                latch_r <= prog_data_i[15:8];
            end else if (wr_ok & hit_latch) begin
                latch_r <= wb_dat_i[7:0];
            end
            if (wr_ok & hit_sect) begin
                section_r <= wb_dat_i[DMEM_AW-SECT_AW-1:0];
            end
        end
    end

    // data memory: one write port shared by execution, table return and the bus
    always_ff @(posedge clk_i) begin
        if (state_r == mie_pkg::ST_TABLE_WAIT && prog_valid_i) begin
            dmem[tbl_dest_r] <= prog_data_i[7:0];
        end else if (start & wr_m) begin
            dmem[op_addr] <= res;
        end else if (wr_ok & is_dmem) begin
            dmem[bus_dmem_addr] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle, ack dropped the cycle after

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= bus_req;
            if (bus_req) begin
                wb_dat_r <= rd_mux;
            end
        end
    end

    assign wb_dat_o = wb_dat_r;
    assign wb_ack_o = wb_ack_r;
    assign prog_addr_o = prog_addr_r;
    assign prog_rd_o = prog_rd_r;
    // own flop so the pin carries no gate after the registers
    assign busy_o = busy_r;
    assign skip_o = skip_r;

endmodule : mie_execute
`default_nettype wire

// ### mie_execute_sva.sv
/* port checker for mie_execute.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module mie_execute_sva #(
    parameter int PROG_AW = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [PROG_AW-1:0] prog_addr_o,
    input wire logic prog_rd_o,
    input wire logic prog_valid_i,
    input wire logic busy_o,
    input wire logic skip_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire cmd_w = take_w && wb_we_i && (wb_adr_i == 12'h000);
    ////////////////////////////////////////////////////////////////
    a_ack_after_take: assert property (take_w |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_skip_from_cmd: assert property ($rose(skip_o) |-> $past(cmd_w))
        else $error("skip without command");
    a_skip_one_cycle: assert property (skip_o |=> !skip_o && !busy_o)
        else $error("dummy cycle too long");
    // dummy cycle must not be mistaken for a table fetch
    a_busy_source: assert property (busy_o == (prog_rd_o || skip_o) && !(prog_rd_o && skip_o))
        else $error("busy mismatch");
    a_read_from_cmd: assert property ($rose(prog_rd_o) |-> $past(cmd_w))
        else $error("fetch without command");
    a_read_held: assert property (prog_rd_o && !prog_valid_i |=> prog_rd_o && $stable(prog_addr_o))
        else $error("fetch not held");
    a_read_ends: assert property (prog_rd_o && prog_valid_i |=> !prog_rd_o)
        else $error("fetch not ended");
endmodule : mie_execute_sva
bind mie_execute mie_execute_sva #(.PROG_AW(PROG_AW)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
    .prog_valid_i(prog_valid_i), .busy_o(busy_o), .skip_o(skip_o));
`default_nettype wire

// ### mie_prog_model.sv
/* program memory model for table reads.
   assumes the read request is held until valid is seen. */
`timescale 1ns/1ps
`default_nettype none
module mie_prog_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic prog_rd_i,
    input wire logic [11:0] prog_addr_i,
    input wire logic [3:0] wait_i,
    output logic prog_valid_o,
    output logic [15:0] prog_data_o
);
    logic [3:0] cnt_r;
    // both bytes depend on page and offset, so a wrong page shows
    wire [15:0] word_w = {prog_addr_i[11:4] ^ 8'h5a, prog_addr_i[7:0] + {4'h0, prog_addr_i[11:8]}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
            prog_valid_o <= 1'b0;
            prog_data_o <= 16'h0000;
        end else if (prog_rd_i && !prog_valid_o && cnt_r == wait_i) begin
            prog_valid_o <= 1'b1;
            prog_data_o <= word_w;
            cnt_r <= 4'h0;
        end else begin
            prog_valid_o <= 1'b0;
            // the last word is inverted every cycle outside a valid beat
            prog_data_o <= ~prog_data_o;
            cnt_r <= cnt_r + {3'h0, prog_rd_i && !prog_valid_o};
        end
    end
endmodule : mie_prog_model
`default_nettype wire

// ### mie_execute_tb_top.sv
/* self-checking bench for mie_execute.
   assumes the checker bind and the program model. */
`timescale 1ns/1ps
`default_nettype none
module mie_execute_tb_top;
    logic clk_i, rst_i, cyc, we, ack, prd, pv, busy, skip;
    logic [11:0] adr, pa;
    logic [31:0] di, rd, got;
    logic [15:0] pd;
    logic [3:0] wt;
    int mismatches = 0;
    int compares = 0;
    int cyc_n = 0;
    mie_execute uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(di), .wb_dat_o(rd), .wb_ack_o(ack), .prog_addr_o(pa),
        .prog_rd_o(prd), .prog_valid_i(pv), .prog_data_i(pd), .busy_o(busy), .skip_o(skip));
    mie_prog_model u_prog (.clk_i(clk_i), .rst_i(rst_i), .prog_rd_i(prd), .prog_addr_i(pa),
        .wait_i(wt), .prog_valid_o(pv), .prog_data_o(pd));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one classic cycle; read data taken at the ack edge
    task automatic wbx(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        di <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        got = rd;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wbx
    function automatic logic [11:0] ma(input logic [8:0] a);
        return {1'b1, a, 2'b00};
    endfunction : ma
    ////////////////////////////////////////////////////////////////
    task automatic ext(input mie_pkg::mie_op_e op, input logic [2:0] b, input logic [7:0] w, m,
        input logic [4:0] fl, input logic [7:0] ew, em, input logic [4:0] ef, input logic es);
        wbx(1'b1, 12'h008, {24'h0, w});
        wbx(1'b1, ma(9'h1a0), {24'h0, m});
        wbx(1'b1, 12'h00c, {27'h0, fl});
        wbx(1'b1, 12'h000, {m, 7'h00, op, b, 9'h1a0});
        wbx(1'b0, 12'h008, 32'h0);
        chk(got, {24'h0, ew});
        wbx(1'b0, ma(9'h1a0), 32'h0);
        chk(got, {24'h0, em});
        wbx(1'b0, 12'h00c, 32'h0);
        chk(got, {27'h0, ef});
        wbx(1'b0, 12'h004, 32'h0);
        chk(got, {30'h0, es, 1'b0});
    endtask : ext
    task automatic tbl(input mie_pkg::mie_op_e op, input logic [7:0] lo, hi, input logic [3:0] t,
        input logic [11:0] a, input logic [7:0] la);
        logic [15:0] e;
        e = {a[11:4] ^ 8'h5a, a[7:0] + {4'h0, a[11:8]}};
        wt <= t;
        wbx(1'b1, 12'h008, 32'h0);
        wbx(1'b1, 12'h010, {24'h0, lo});
        wbx(1'b1, 12'h014, {24'h0, hi});
        wbx(1'b1, 12'h000, {15'h0, op, 12'h1a0});
        wbx(1'b1, 12'h008, 32'hee);
        do wbx(1'b0, 12'h004, 32'h0); while (got[0] !== 1'b0);
        wbx(1'b0, 12'h008, 32'h0);
        chk(got, (t == 4'h0) ? 32'hee : 32'h0);
        wbx(1'b0, ma(9'h1a0), 32'h0);
        chk(got, {24'h0, e[7:0]});
        wbx(1'b0, 12'h018, 32'h0);
        chk(got, {24'h0, e[15:8]});
        wbx(1'b0, 12'h010, 32'h0);
        chk(got, {24'h0, la});
    endtask : tbl
    ////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        di = 32'h0;
        wt = 4'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 1; i < 9; i++) begin
            wbx(1'b0, 12'(i * 4), 32'h0);
            chk(got, 32'h0);
        end
        wbx(1'b1, 12'h040, 32'hffff_ffff);
        wbx(1'b0, 12'h040, 32'h0);
        chk(got, 32'h0);
        wbx(1'b1, 12'h01c, 32'h3);
        ext(mie_pkg::OP_NIBBLE_SWAP_TO_W,0,8'h00,8'h3c,5'h1f,8'hc3,8'h3c,5'h1f,0);
        ext(mie_pkg::OP_SKIP_IF_ZERO,0,8'h11,8'h00,5'h1f,8'h11,8'h00,5'h1f,1);
        ext(mie_pkg::OP_SKIP_IF_ZERO,0,8'h11,8'h10,5'h1f,8'h11,8'h10,5'h1f,0);
        ext(mie_pkg::OP_SKIP_ZERO_LOAD_W,0,8'h11,8'h00,5'h1f,8'h00,8'h00,5'h1f,1);
        ext(mie_pkg::OP_SKIP_IF_BIT_ZERO,4,8'h11,8'h10,5'h1f,8'h11,8'h10,5'h1f,0);
        ext(mie_pkg::OP_SKIP_IF_BIT_ZERO,3,8'h11,8'h10,5'h1f,8'h11,8'h10,5'h1f,1);
        ext(mie_pkg::OP_XOR_TO_W,0,8'h5a,8'h5a,5'h01,8'h00,8'h5a,5'h05,0);
        ext(mie_pkg::OP_XOR_TO_MEMORY,0,8'hf0,8'h0f,5'h04,8'hf0,8'hff,5'h00,0);
        ext(mie_pkg::OP_XOR_IMMEDIATE,0,8'h0f,8'hff,5'h04,8'hf0,8'hff,5'h00,0);
        ext(mie_pkg::OP_EXT_ADD_CARRY,0,8'h0e,8'h01,5'h01,8'h10,8'h01,5'h02,0);
        ext(mie_pkg::OP_EXT_ADD_CARRY_TO_MEM,0,8'h80,8'h80,5'h01,8'h80,8'h01,5'h19,0);
        ext(mie_pkg::OP_EXT_ADD,0,8'h7f,8'h01,5'h00,8'h80,8'h01,5'h0a,0);
        ext(mie_pkg::OP_EXT_ADD_TO_MEM,0,8'hff,8'h01,5'h00,8'hff,8'h00,5'h07,0);
        ext(mie_pkg::OP_EXT_AND,0,8'hf0,8'h0f,5'h1b,8'h00,8'h0f,5'h1f,0);
        ext(mie_pkg::OP_EXT_AND_TO_MEM,0,8'h3c,8'h0f,5'h04,8'h3c,8'h0c,5'h00,0);
        ext(mie_pkg::OP_EXT_CLEAR,0,8'h11,8'hff,5'h15,8'h11,8'h00,5'h15,0);
        ext(mie_pkg::OP_EXT_CLEAR_BIT,3,8'h11,8'hff,5'h15,8'h11,8'hf7,5'h15,0);
        ext(mie_pkg::OP_EXT_INVERT,0,8'h11,8'hff,5'h00,8'h11,8'h00,5'h04,0);
        ext(mie_pkg::OP_EXT_INVERT_TO_W,0,8'h00,8'h0f,5'h04,8'hf0,8'h0f,5'h00,0);
        ext(mie_pkg::OP_EXT_DECIMAL_ADJUST,0,8'h15,8'h00,5'h03,8'h15,8'h7b,5'h03,0);
        ext(mie_pkg::OP_EXT_DECIMAL_ADJUST,0,8'hb2,8'h00,5'h04,8'hb2,8'h12,5'h05,0);
        ext(mie_pkg::OP_EXT_DECREMENT,0,8'h11,8'h01,5'h00,8'h11,8'h00,5'h04,0);
        ext(mie_pkg::OP_EXT_DECREMENT_TO_W,0,8'h11,8'h00,5'h04,8'hff,8'h00,5'h00,0);
        ext(mie_pkg::OP_EXT_INCREMENT,0,8'h11,8'hff,5'h00,8'h11,8'h00,5'h04,0);
        ext(mie_pkg::OP_EXT_INCREMENT_TO_W,0,8'h11,8'h41,5'h04,8'h42,8'h41,5'h00,0);
        ext(mie_pkg::OP_EXT_MOVE_TO_W,0,8'h00,8'h77,5'h1f,8'h77,8'h77,5'h1f,0);
        ext(mie_pkg::OP_EXT_MOVE_TO_MEM,0,8'h66,8'h00,5'h1f,8'h66,8'h66,5'h1f,0);
        tbl(mie_pkg::OP_TABLE_READ_PAGE, 8'h34, 8'h05, 4'h0, 12'h534, 8'h34);
        tbl(mie_pkg::OP_TABLE_READ_FINAL_PAGE, 8'h34, 8'h05, 4'h3, 12'hf34, 8'h34);
        tbl(mie_pkg::OP_TABLE_READ_PREINC, 8'hff, 8'h02, 4'h6, 12'h200, 8'h00);
        tbl(mie_pkg::OP_TABLE_READ_FINAL_PREINC, 8'h7e, 8'h02, 4'h9, 12'hf7f, 8'h7f);
        wbx(1'b1, ma(9'h0a0), 32'h99);
        wbx(1'b1, 12'h000, {15'h0, mie_pkg::OP_EXT_MOVE_TO_W, 12'h0a0});
        wbx(1'b0, 12'h008, 32'h0);
        chk(got, 32'h99);
        wbx(1'b0, 12'h020, 32'h0);
        chk(got, 32'h3);
        stop_test();
    end
endmodule : mie_execute_tb_top
`default_nettype wire
